// [src/scr_pkg.sv]
// Purpose: Constants and types for the sensor configuration register bank
// Assumes: APB byte address is four times the register index
// Notes:   Each entry of the table gives index, reset value and writable bits
package scr_pkg;

  localparam int          NREG          = 45;
  localparam int          AW            = 12;
  localparam logic [6:0]  OFS_LANE_LO   = 7'h50;
  localparam logic [6:0]  OFS_LANE_MID  = 7'h51;
  localparam logic [6:0]  OFS_LANE_HI   = 7'h52;
  localparam logic [6:0]  OFS_DARK_LO   = 7'h64;
  localparam logic [6:0]  OFS_DARK_HI   = 7'h65;
  localparam logic [6:0]  OFS_AMP_GAIN  = 7'h66;
  localparam logic [6:0]  OFS_RAMP_GAIN = 7'h67;
  localparam logic [6:0]  OFS_LANE_CNT  = 7'h48;
  localparam logic [6:0]  OFS_IDENTITY  = 7'h7D;
  localparam logic [6:0]  OFS_THERM_LO  = 7'h7E;
  localparam logic [6:0]  OFS_THERM_HI  = 7'h7F;
  localparam logic [14:0] ADC_FIXED_OFS = 15'h0046;
  localparam logic [13:0] DARK_RST      = 14'h3FC3;

  typedef struct packed {
    logic [6:0] ofs;
    logic [7:0] rst;
    logic [7:0] mask;
  } scr_entry_t;

  localparam scr_entry_t REG_TABLE [NREG] = '{
    '{7'h01, 8'h40, 8'hFF}, '{7'h02, 8'h04, 8'hFF}, '{7'h03, 8'h00, 8'hFF}, '{7'h04, 8'h00, 8'hFF},
    '{7'h23, 8'h00, 8'hFF}, '{7'h24, 8'h00, 8'hFF}, '{7'h25, 8'h00, 8'hFF}, '{7'h26, 8'h00, 8'hFF},
    '{7'h27, 8'h01, 8'h01}, '{7'h28, 8'h00, 8'h03}, '{7'h29, 8'h00, 8'hFF}, '{7'h2A, 8'h40, 8'hFF},
    '{7'h2B, 8'h04, 8'hFF}, '{7'h2C, 8'h00, 8'hFF}, '{7'h36, 8'h01, 8'h03}, '{7'h37, 8'h01, 8'hFF},
    '{7'h46, 8'h01, 8'hFF}, '{7'h47, 8'h00, 8'hFF}, '{OFS_LANE_CNT, 8'h00, 8'h03},
    '{7'h49, 8'h0A, 8'hFF}, '{7'h4E, 8'h55, 8'hFF}, '{7'h4F, 8'h00, 8'h0F},
    '{OFS_LANE_LO, 8'hFF, 8'hFF}, '{OFS_LANE_MID, 8'hFF, 8'hFF}, '{OFS_LANE_HI, 8'h03, 8'h07},
    '{7'h53, 8'h08, 8'hFF}, '{7'h54, 8'h08, 8'h0F}, '{7'h55, 8'h08, 8'h0F}, '{7'h58, 8'h60, 8'h7F},
    '{7'h5B, 8'h60, 8'h7F}, '{7'h5E, 8'h60, 8'h7F}, '{7'h5F, 8'h60, 8'h7F}, '{7'h62, 8'h60, 8'h7F},
    '{7'h63, 8'h60, 8'h7F}, '{OFS_DARK_LO, 8'hC3, 8'hFF}, '{OFS_DARK_HI, 8'h3F, 8'h3F},
    '{OFS_AMP_GAIN, 8'h00, 8'h03}, '{OFS_RAMP_GAIN, 8'h20, 8'hFF},
    '{7'h6C, 8'h00, 8'h0F}, '{7'h6D, 8'h01, 8'h0F}, '{7'h6F, 8'h01, 8'h01}, '{7'h70, 8'h00, 8'h03},
    '{7'h73, 8'h00, 8'h01}, '{7'h75, 8'h08, 8'hFF}, '{7'h00, 8'h00, 8'h00}
  };

  typedef struct packed {
    logic [15:0]        data_lane_en;
    logic               clk_lane_en;
    logic               ctrl_lane_en;
    logic               link_clk_in_en;
    logic signed [13:0] dark_offset;
    logic signed [14:0] dark_level;
    logic [1:0]         col_amp_gain;
    logic [4:0]         col_gain_x10;
    logic [7:0]         ramp_slope;
    logic [4:0]         lanes_active;
  } scr_cfg_t;

  typedef struct packed {
    logic [127:0][7:0] bytes;
    logic [31:0]       prdata;
    logic              pslverr;
    scr_cfg_t          cfg;
  } scr_state_t;

endpackage : scr_pkg

// [src/scr_bank.sv]
// Purpose: Sensor configuration register bank behind an APB slave
// Assumes: mclk at 50 MHz, synchronous active-low reset, zero-wait APB
// Notes:   Byte registers sit in bits 7:0 of aligned words
// Behaviour
// - No register depends on input clock rate
// - Lane enable bits 0-15 switch data lanes
// - Bits 16-18 gate clock, control, link-clock input
// - Dark offset is 14-bit two's complement
// - Dark level equals seventy plus signed offset
// - Dark offset resets to 16323, minus sixty-one
// - Offset low byte at 100, upper six at 101
// - Column gain codes give x1, x1.2, x1.4, x1.6
// - Ramp gain byte sets converter ramp slope
// - Byte 125 returns fixed sensor identity code
// - Lane count codes give 16, 8, 4, 2 lanes
`timescale 1ns/1ps
module scr_bank #(
  parameter logic [7:0] SENSOR_ID = 8'h5A  // Arbitrary value
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [scr_pkg::AW-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic [15:0]           thermal_value,
  output scr_pkg::scr_cfg_t          cfg
);
  import scr_pkg::*;

  function automatic scr_cfg_t derive(input logic [127:0][7:0] b);
    scr_cfg_t c;
    c                = '0;
    c.data_lane_en   = {b[OFS_LANE_MID], b[OFS_LANE_LO]};
    c.clk_lane_en    = b[OFS_LANE_HI][0];
    c.ctrl_lane_en   = b[OFS_LANE_HI][1];
    c.link_clk_in_en = b[OFS_LANE_HI][2];
    c.dark_offset    = {b[OFS_DARK_HI][5:0], b[OFS_DARK_LO]};
    c.dark_level     = $signed(ADC_FIXED_OFS) + $signed({c.dark_offset[13], c.dark_offset});
    c.col_amp_gain   = b[OFS_AMP_GAIN][1:0];
    unique case (c.col_amp_gain)
      2'h0: c.col_gain_x10 = 5'h0A;
      2'h1: c.col_gain_x10 = 5'h0C;
      2'h2: c.col_gain_x10 = 5'h0E;
      2'h3: c.col_gain_x10 = 5'h10;
    endcase
    c.ramp_slope     = b[OFS_RAMP_GAIN];
    unique case (b[OFS_LANE_CNT][1:0])
      2'h0: c.lanes_active = 5'h10;
      2'h1: c.lanes_active = 5'h08;
      2'h2: c.lanes_active = 5'h04;
      2'h3: c.lanes_active = 5'h02;
    endcase
    return c;
  endfunction : derive

  function automatic scr_state_t reset_state();
    scr_state_t s;
    s = '0;
    for (int i = 0; i < NREG; i++)
    begin
      s.bytes[REG_TABLE[i].ofs] = REG_TABLE[i].rst;
    end
    s.cfg = derive(s.bytes);
    return s;
  endfunction : reset_state

  localparam scr_state_t ST_RST = reset_state();

  scr_state_t state_q;
  scr_state_t state_d;
  logic [6:0] idx;
  logic       in_range;
  logic       rw_hit;
  logic       ro_hit;
  logic [7:0] wmask;
  logic [7:0] rbyte;

  assign pready  = 1'b1;
  assign prdata  = state_q.prdata;
  assign pslverr = state_q.pslverr;
  assign cfg     = state_q.cfg;
  assign idx      = paddr[8:2];
  assign in_range = (paddr[AW-1:9] == '0);

  // Address decode against the register table
  always_comb
  begin
    rw_hit = 1'b0;
    wmask  = 8'h00;
    for (int i = 0; i < NREG - 1; i++)
    begin
      if (in_range && idx == REG_TABLE[i].ofs)
      begin
        rw_hit = 1'b1;
        wmask  = REG_TABLE[i].mask;
      end
    end
    ro_hit = in_range && (idx == OFS_IDENTITY || idx == OFS_THERM_LO || idx == OFS_THERM_HI);
    if (idx == OFS_IDENTITY)
      rbyte = SENSOR_ID;
    else if (idx == OFS_THERM_LO)
      rbyte = thermal_value[7:0];
    else if (idx == OFS_THERM_HI)
      rbyte = thermal_value[15:8];
    else
      rbyte = state_q.bytes[idx];
  end

  // Next state: read data latched in setup, write at access
  always_comb
  begin
    state_d = state_q;
    if (psel && !penable)
    begin
      state_d.pslverr = !(rw_hit || ro_hit) || (pwrite && ro_hit);
      state_d.prdata  = (!pwrite && (rw_hit || ro_hit)) ? {24'h0, rbyte} : 32'h0;
    end
    if (psel && penable && pwrite && rw_hit && pstrb[0])
    begin
      state_d.bytes[idx] = pwdata[7:0] & wmask;
    end
    state_d.cfg = derive(state_d.bytes);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_q <= ST_RST;
    else
      state_q <= state_d;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic wr_acc;
  assign wr_acc = psel && penable && pwrite && pstrb[0] && in_range;

  property p_data_lanes;
    wr_acc && idx == OFS_LANE_LO |=> cfg.data_lane_en[7:0] == $past(pwdata[7:0]);
  endproperty
  a_data_lanes: assert property (p_data_lanes) else $error("Data lane enable mismatch");

  property p_side_lanes;
    wr_acc && idx == OFS_LANE_HI |=> {cfg.link_clk_in_en, cfg.ctrl_lane_en, cfg.clk_lane_en} == $past(pwdata[2:0]);
  endproperty
  a_side_lanes: assert property (p_side_lanes) else $error("Clock or control lane gate mismatch");

  property p_sign;
    cfg.dark_offset[13] == (cfg.dark_offset < 0);
  endproperty
  a_sign: assert property (p_sign) else $error("Dark offset sign wrong");

  property p_dark_level;
    cfg.dark_level == 15'sd70 + 15'(cfg.dark_offset);
  endproperty
  a_dark_level: assert property (p_dark_level) else $error("Dark level not seventy plus offset");

  property p_dark_reset;
    !$past(rst_n) |-> cfg.dark_offset == 14'sh3FC3 && cfg.dark_level == 15'sd9;
  endproperty
  a_dark_reset: assert property (p_dark_reset) else $error("Dark offset reset value wrong");

  property p_dark_hi;
    wr_acc && idx == OFS_DARK_HI
      |=> cfg.dark_offset[13:8] == $past(pwdata[5:0]) && cfg.dark_offset[7:0] == $past(cfg.dark_offset[7:0]);
  endproperty
  a_dark_hi: assert property (p_dark_hi) else $error("Offset upper bits misplaced");

  property p_identity;
    psel && !penable && !pwrite && in_range && idx == OFS_IDENTITY |=> prdata == {24'h0, SENSOR_ID} && !pslverr;
  endproperty
  a_identity: assert property (p_identity) else $error("Identity read wrong");

  property p_lane_count;
    (state_q.bytes[OFS_LANE_CNT][1:0] == 2'h3 |-> cfg.lanes_active == 5'h02) and
    (state_q.bytes[OFS_LANE_CNT][1:0] == 2'h0 |-> cfg.lanes_active == 5'h10);
  endproperty
  a_lane_count: assert property (p_lane_count) else $error("Lane count decode wrong");

  property p_unused_zero;
    psel && !penable && !pwrite && in_range && idx == OFS_LANE_HI |=> prdata[31:3] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bits read nonzero");

  property p_lane_mid;
    wr_acc && idx == OFS_LANE_MID
      |=> cfg.data_lane_en[15:8] == $past(pwdata[7:0]);
  endproperty
  a_lane_mid: assert property (p_lane_mid) else $error("Upper data lane enable mismatch");

  property p_lane_quiet;
    !(wr_acc && (idx == OFS_LANE_LO || idx == OFS_LANE_MID))
      |=> $stable(cfg.data_lane_en);
  endproperty
  a_lane_quiet: assert property (p_lane_quiet) else $error("Data lanes changed without write");

  property p_side_quiet;
    !(wr_acc && idx == OFS_LANE_HI)
      |=> $stable({cfg.clk_lane_en, cfg.ctrl_lane_en, cfg.link_clk_in_en});
  endproperty
  a_side_quiet: assert property (p_side_quiet) else $error("Side lane gates changed without write");

  property p_lane_reset;
    !$past(rst_n)
      |-> cfg.data_lane_en == 16'hFFFF && cfg.clk_lane_en && cfg.ctrl_lane_en && !cfg.link_clk_in_en;
  endproperty
  a_lane_reset: assert property (p_lane_reset) else $error("Lane gates wrong after reset");

  property p_dark_lo;
    wr_acc && idx == OFS_DARK_LO
      |=> cfg.dark_offset[7:0] == $past(pwdata[7:0]) && cfg.dark_offset[13:8] == $past(cfg.dark_offset[13:8]);
  endproperty
  a_dark_lo: assert property (p_dark_lo) else $error("Offset low byte misplaced");

  property p_dark_quiet;
    !(wr_acc && (idx == OFS_DARK_LO || idx == OFS_DARK_HI))
      |=> $stable(cfg.dark_offset) && $stable(cfg.dark_level);
  endproperty
  a_dark_quiet: assert property (p_dark_quiet) else $error("Dark offset changed without write");

  property p_dark_pos;
    !cfg.dark_offset[13]
      |-> cfg.dark_level >= 15'sd70;
  endproperty
  a_dark_pos: assert property (p_dark_pos) else $error("Positive offset lowered dark level");

  property p_dark_neg;
    cfg.dark_offset[13]
      |-> cfg.dark_level < 15'sd70;
  endproperty
  a_dark_neg: assert property (p_dark_neg) else $error("Negative offset raised dark level");

  property p_amp_gain;
    wr_acc && idx == OFS_AMP_GAIN
      |=> cfg.col_amp_gain == $past(pwdata[1:0]);
  endproperty
  a_amp_gain: assert property (p_amp_gain) else $error("Column gain code mismatch");

  property p_gain_ends;
    (cfg.col_amp_gain == 2'h0 |-> cfg.col_gain_x10 == 5'h0A) and
    (cfg.col_amp_gain == 2'h3 |-> cfg.col_gain_x10 == 5'h10);
  endproperty
  a_gain_ends: assert property (p_gain_ends) else $error("Column gain end codes wrong");

  property p_gain_mid;
    (cfg.col_amp_gain == 2'h1 |-> cfg.col_gain_x10 == 5'h0C) and
    (cfg.col_amp_gain == 2'h2 |-> cfg.col_gain_x10 == 5'h0E);
  endproperty
  a_gain_mid: assert property (p_gain_mid) else $error("Column gain middle codes wrong");

  property p_ramp_gain;
    wr_acc && idx == OFS_RAMP_GAIN
      |=> cfg.ramp_slope == $past(pwdata[7:0]);
  endproperty
  a_ramp_gain: assert property (p_ramp_gain) else $error("Ramp slope mismatch");

  property p_ramp_quiet;
    !(wr_acc && idx == OFS_RAMP_GAIN)
      |=> $stable(cfg.ramp_slope);
  endproperty
  a_ramp_quiet: assert property (p_ramp_quiet) else $error("Ramp slope changed without write");

  property p_cfg_reset;
    !$past(rst_n)
      |-> cfg.ramp_slope == 8'h20 && cfg.col_amp_gain == 2'h0 && cfg.lanes_active == 5'h10;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("Gain or lane count wrong after reset");

  property p_count_mid;
    (state_q.bytes[OFS_LANE_CNT][1:0] == 2'h1 |-> cfg.lanes_active == 5'h08) and
    (state_q.bytes[OFS_LANE_CNT][1:0] == 2'h2 |-> cfg.lanes_active == 5'h04);
  endproperty
  a_count_mid: assert property (p_count_mid) else $error("Lane count middle codes wrong");

  property p_count_write;
    wr_acc && idx == OFS_LANE_CNT && pwdata[1:0] == 2'h2
      |=> cfg.lanes_active == 5'h04;
  endproperty
  a_count_write: assert property (p_count_write) else $error("Lane count write not decoded");

  property p_cfg_quiet;
    !(psel && penable && pwrite)
      |=> $stable(cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("Configuration changed without write");

  property p_therm_lo;
    psel && !penable && !pwrite && in_range && idx == OFS_THERM_LO
      |=> prdata == {24'h0, $past(thermal_value[7:0])} && !pslverr;
  endproperty
  a_therm_lo: assert property (p_therm_lo) else $error("Thermal low byte read wrong");

  property p_therm_hi;
    psel && !penable && !pwrite && in_range && idx == OFS_THERM_HI
      |=> prdata == {24'h0, $past(thermal_value[15:8])} && !pslverr;
  endproperty
  a_therm_hi: assert property (p_therm_hi) else $error("Thermal high byte read wrong");

  property p_ro_write;
    psel && !penable && pwrite && ro_hit
      |=> pslverr && prdata == 32'h0;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Read-only write not refused");

  property p_unmapped;
    psel && !penable && !rw_hit && !ro_hit
      |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");

  property p_write_rdata;
    psel && !penable && pwrite
      |=> prdata == 32'h0;
  endproperty
  a_write_rdata: assert property (p_write_rdata) else $error("Read data nonzero on write");

  property p_read_hit;
    psel && !penable && !pwrite && rw_hit
      |=> prdata == {24'h0, $past(state_q.bytes[idx])} && !pslverr;
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("Register read data wrong");

  property p_read_unused;
    psel && !penable && !pwrite && rw_hit
      |=> (prdata[7:0] & ~$past(wmask)) == 8'h00;
  endproperty
  a_read_unused: assert property (p_read_unused) else $error("Unused register bits read nonzero");

  property p_strobe_off;
    psel && penable && pwrite && !pstrb[0]
      |=> $stable(state_q.bytes);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("Write without strobe landed");

  property p_answer_stands;
    !(psel && !penable)
      |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_answer_stands: assert property (p_answer_stands) else $error("Answer changed outside setup");

  genvar g;
  generate
    for (g = 0; g < NREG - 1; g++)
    begin : g_entry
      property p_entry_reset;
        !$past(rst_n) |-> state_q.bytes[REG_TABLE[g].ofs] == REG_TABLE[g].rst;
      endproperty
      a_entry_reset: assert property (p_entry_reset) else $error("Register reset value wrong");

      property p_entry_write;
        wr_acc && idx == REG_TABLE[g].ofs
          |=> state_q.bytes[REG_TABLE[g].ofs] == ($past(pwdata[7:0]) & REG_TABLE[g].mask);
      endproperty
      a_entry_write: assert property (p_entry_write) else $error("Masked register write wrong");
    end
  endgenerate

endmodule : scr_bank

// [tb/scr_ctrl_model.sv]
// Purpose: Camera controller model driving the register port
// Assumes: Slave may add wait states; master waits for pready
// Notes:   Released write data shows the inverse of its last value
`timescale 1ns/1ps
module scr_ctrl_model (
  input  wire logic        mclk,
  output logic [11:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial
  begin
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
  end

  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic [6:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] st,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {3'h0, idx, 2'h0};
    pwdata  <= {24'h000000, d};
    pstrb   <= st;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask : xfer
endmodule : scr_ctrl_model

// [tb/sensor_config_register_bank_test.sv]
// Purpose: Self-checking bench for the sensor configuration register bank
// Assumes: Byte address is four times the register index
// Notes:   Random data from a fixed seed plus corner offsets
`timescale 1ns/1ps
module sensor_config_register_bank_test;
  import scr_pkg::*;
  localparam logic [7:0] ID = 8'hA7;  // Arbitrary value
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic [7:0]  rg, rs;
  logic [31:0] r0;
  logic        x_err;
  logic [15:0] thermal_value = 16'h0000;
  scr_cfg_t    cfg;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [13:0] corner [4] = '{14'h1FFF, 14'h2000, 14'h3FFF, 14'h0000};
  logic [14:0] rec [11] = '{ {7'h52, 8'h07}, {7'h54, 8'h04}, {7'h55, 8'h01}, {7'h58, 8'h40}, {7'h5B, 8'h40},
                             {7'h5E, 8'h65}, {7'h5F, 8'h6A}, {7'h73, 8'h01}, {7'h75, 8'h09}, {7'h49, 8'h05},
                             {7'h53, 8'h04}};

  always #10 mclk = ~mclk;

  scr_bank #(.SENSOR_ID(ID)) scr_bank_i (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .thermal_value(thermal_value), .cfg(cfg));
  scr_ctrl_model scr_ctrl_model_i (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  function automatic logic signed [14:0] dl(input logic [13:0] o);
    return 15'sd70 + $signed(o);
  endfunction : dl

  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic acc(input logic [6:0] idx, input logic w, input logic [7:0] d, input logic [7:0] e,
                     input logic ee);
    logic [31:0] r;
    logic        x;
    scr_ctrl_model_i.xfer(idx, w, d, 4'hF, r, x);
    cmp(r, {24'h000000, e});
    cmp({31'h0, x}, {31'h0, ee});
  endtask : acc

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    acc(idx, 1'b1, d, 8'h00, 1'b0);
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(56));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    cmp(cfg.dark_level, 32'd9);
    acc(OFS_DARK_LO, 1'b0, 8'h00, 8'hC3, 1'b0);
    acc(OFS_DARK_HI, 1'b0, 8'h00, 8'h3F, 1'b0);
    acc(OFS_LANE_HI, 1'b0, 8'h00, 8'h03, 1'b0);
    acc(OFS_RAMP_GAIN, 1'b0, 8'h00, 8'h20, 1'b0);
    acc(OFS_IDENTITY, 1'b1, 8'h11, 8'h00, 1'b1);
    acc(OFS_IDENTITY, 1'b0, 8'h00, ID, 1'b0);
    acc(7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    wr(OFS_LANE_HI, 8'hFF);
    acc(OFS_LANE_HI, 1'b0, 8'h00, 8'h07, 1'b0);
    cmp({cfg.clk_lane_en, cfg.ctrl_lane_en, cfg.link_clk_in_en}, 32'h7);
    wr(OFS_LANE_HI, 8'h02);
    cmp({cfg.clk_lane_en, cfg.ctrl_lane_en, cfg.link_clk_in_en}, 32'h2);
    @(posedge mclk);
    v = $urandom;
    thermal_value <= v[15:0];
    acc(OFS_THERM_LO, 1'b0, 8'h00, v[7:0], 1'b0);
    acc(OFS_THERM_HI, 1'b0, 8'h00, v[15:8], 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_AMP_GAIN, 8'(c));
      wr(OFS_LANE_CNT, 8'(c));
      cmp(cfg.col_amp_gain, c);
      cmp(cfg.col_gain_x10, 10 + 2 * c);
      cmp(cfg.lanes_active, 16 >> c);
    end
    foreach (rec[k])
      wr(rec[k][14:8], rec[k][7:0]);
    foreach (rec[k])
      acc(rec[k][14:8], 1'b0, 8'h00, rec[k][7:0], 1'b0);
    v = $urandom;
    rs = 8'h66 + {5'h00, v[2:0]};
    rg = 8'h28 + {4'h0, v[11:8]};
    wr(7'h62, rs);
    wr(7'h63, rs);
    wr(OFS_RAMP_GAIN, rg);
    cmp(cfg.ramp_slope, rg);
    acc(7'h62, 1'b0, 8'h00, rs, 1'b0);
    acc(7'h63, 1'b0, 8'h00, rs, 1'b0);
    scr_ctrl_model_i.xfer(OFS_RAMP_GAIN, 1'b1, ~rg, 4'hE, r0, x_err);
    cmp(r0, 32'h0);
    cmp({31'h0, x_err}, 32'h0);
    acc(OFS_RAMP_GAIN, 1'b0, 8'h00, rg, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      v = $urandom;
      if (i < 4)
        v[29:16] = corner[i];
      wr(OFS_LANE_LO, v[7:0]);
      wr(OFS_LANE_MID, v[15:8]);
      wr(OFS_DARK_LO, v[23:16]);
      wr(OFS_DARK_HI, v[31:24]);
      wr(OFS_RAMP_GAIN, v[7:0] ^ v[31:24]);
      cmp(cfg.data_lane_en, v[15:0]);
      cmp(cfg.dark_offset, $signed(v[29:16]));
      cmp(cfg.dark_level, dl(v[29:16]));
      cmp(cfg.ramp_slope, v[7:0] ^ v[31:24]);
      acc(OFS_DARK_HI, 1'b0, 8'h00, {2'b00, v[29:24]}, 1'b0);
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    cmp(cfg.dark_level, 32'd9);
    acc(OFS_DARK_HI, 1'b0, 8'h00, 8'h3F, 1'b0);
    acc(OFS_LANE_HI, 1'b0, 8'h00, 8'h03, 1'b0);
    complete_run();
  end
endmodule : sensor_config_register_bank_test
